// >>> tb/sdram_host_model.sv
// host controller model driving the sdram pins
`timescale 1ns/10ps
module sdram_host_model (
  input wire logic clk_sys, // clock
  output logic sdram_clk, // link clock
  output logic cke, // clock enable
  output logic [3:0] cmd, // strobes
  output logic [1:0] ba, // bank
  output logic [11:0] addr, // address
  output logic [1:0] dqm, // masks
  output logic [15:0] dq // data
);
  logic [2:0] ph = 3'h0;
  logic wr = 1'b0;
  logic [15:0] wd = 16'h0;
  logic [15:0] nz = 16'h5A5A;
  initial begin
    sdram_clk = 1'b0;
    {cke, cmd, ba, addr, dqm} = {1'b1, 4'h7, 16'h0};
  end
  // released data lines toggle every cycle
  assign dq = wr ? wd : nz;
  always @(posedge clk_sys) begin
    ph <= ph + 3'h1;
    sdram_clk <= ph[2];
    nz <= ~nz;
  end
  // pins change just after the link falling edge
  task automatic put(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
      input logic [1:0] m, input logic k, input logic [15:0] d, input logic w);
    @(negedge sdram_clk);
    @(posedge clk_sys);
    cmd <= c;
    {ba, addr, dqm} <= {b, a, m};
    cke <= k;
    {wd, wr} <= {d, w};
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the sdram command and bank control block
`timescale 1ns/10ps
module testbench;
  import sdram_cmd_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sdram_clk, cke, cs_n, ras_n, cas_n, we_n, susp, pdn, sref, arp;
  logic [3:0] c4, bopen;
  logic [1:0] ba, dqm;
  logic [11:0] addr;
  logic [15:0] dq, dout, doe, d;
  logic [15:0] ar_n = 16'h0;
  logic [10:0] mword;
  logic [15:0] mem [256];
  logic [15:0] ed [256];
  bit rv [256];
  bit [1:0] mh [256];
  bit dchk = 1'b1;
  int err_count = 0;
  int check_count = 0;
  int e = 0;
  sdram_host_model u_host (.clk_sys(clk_sys), .sdram_clk(sdram_clk), .cke(cke), .cmd(c4),
    .ba(ba), .addr(addr), .dqm(dqm), .dq(dq));
  assign {cs_n, ras_n, cas_n, we_n} = c4;
  sdram_command_bank_control u_dut (.clk_sys(clk_sys), .nrst(nrst), .sdram_clk(sdram_clk),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(ba),
    .addr(addr), .dqm(dqm), .data_pins_in(dq), .data_pins_out(dout), .data_pins_oe(doe),
    .bank_open(bopen), .mode_word(mword), .clock_suspend_on(susp), .power_down_on(pdn),
    .self_refresh_on(sref), .auto_refresh_pulse(arp));
  always @(posedge clk_sys) if (arp === 1'b1) ar_n <= ar_n + 16'h1;
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    check_count++;
    if (s !== x) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one link edge; outputs of the previous edge checked against the model
  task automatic cmd(input cmd_t c, input logic [1:0] b, input logic [11:0] a,
      input logic [1:0] m, input logic k, input logic [15:0] wd, input logic w);
    logic [15:0] x;
    u_host.put(c, b, a, m, k, wd, w);
    if (e > 2 && dchk) begin
      x = rv[e-1] ? {{8{~mh[e-3][1]}}, {8{~mh[e-3][0]}}} : 16'h0;
      chk(doe, x);
      chk(dout & x, ed[e-1] & x);
    end
    mh[e] = m;
    e++;
  endtask
  task automatic nop(input int n, input logic k);
    repeat (n) cmd(CMD_NOP, 2'h0, 12'h0, 2'h0, k, 16'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] col, input logic [1:0] m);
    for (int i = 0; i < 4; i++) begin
      ed[e+2+i] = mem[{col[7:2], col[1:0] + 2'(i)}];
      rv[e+2+i] = 1'b1;
    end
    cmd(CMD_READ, 2'h1, {4'h0, col}, m, 1'b1, 16'h0, 1'b0);
  endtask
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(75402));
    repeat (12) @(posedge clk_sys);
    chk(16'(bopen), 16'h0);
    chk(16'(mword), 16'(MODE_RESET));
    nrst <= 1'b1;
    nop(3, 1'b1);
    cmd(CMD_MODE_SET, 2'h0, 12'h022, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(3, 1'b1);
    chk(16'(mword), 16'h0022);
    cmd(CMD_OPEN_ROW, 2'h1, 12'h005, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(1, 1'b1);
    cmd(CMD_OPEN_ROW, 2'h2, 12'h001, 2'h0, 1'b1, 16'h0, 1'b0);
    cmd(CMD_READ, 2'h0, 12'h004, 2'h0, 1'b1, 16'h0, 1'b0);
    cmd(CMD_MODE_SET, 2'h0, 12'h033, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(2, 1'b1);
    chk(16'(bopen), 16'h0006);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      mem[8'(4 + i)] = d;
      cmd(i == 0 ? CMD_WRITE : CMD_NOP, 2'h1, 12'h004, 2'h0, 1'b1, d, 1'b1);
    end
    nop(1, 1'b1);
    chk(16'(mword), 16'h0022);
    rd(8'h06, 2'h0);
    cmd(CMD_NOP, 2'h0, 12'h0, 2'h1, 1'b1, 16'h0, 1'b0);
    nop(4, 1'b1);
    rd(8'h06, 2'h2);
    rd(8'h04, 2'h0);
    nop(7, 1'b1);
    cmd(CMD_CLOSE, 2'h1, 12'h000, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(1, 1'b1);
    chk(16'(bopen), 16'h0004);
    cmd(CMD_CLOSE, 2'h0, 12'h400, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(1, 1'b1);
    chk(16'(bopen), 16'h0);
    cmd(CMD_MODE_SET, 2'h0, 12'h027, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(3, 1'b1);
    chk(16'(mword), 16'h0027);
    cmd(CMD_OPEN_ROW, 2'h1, 12'h001, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(2, 1'b1);
    for (int i = 0; i < 2; i++) begin
      d = 16'($urandom);
      mem[8'(255 + i)] = d;
      cmd(i == 0 ? CMD_WRITE : CMD_NOP, 2'h1, 12'h0FF, 2'h0, 1'b1, d, 1'b1);
    end
    cmd(CMD_BURST_STOP, 2'h1, 12'h0FF, 2'h0, 1'b1, 16'h0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      ed[e + 2 + i] = mem[8'(255 + i)];
      rv[e + 2 + i] = 1'b1;
    end
    cmd(CMD_READ, 2'h1, 12'h4FF, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(1, 1'b1);
    cmd(CMD_CLOSE, 2'h1, 12'h000, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(4, 1'b1);
    chk(16'(bopen), 16'h0);
    cmd(CMD_MODE_SET, 2'h0, 12'h022, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(3, 1'b1);
    cmd(CMD_REFRESH, 2'h0, 12'h0, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(1, 1'b1);
    chk(ar_n, 16'h0001);
    cmd(CMD_REFRESH, 2'h0, 12'h0, 2'h0, 1'b0, 16'h0, 1'b0);
    nop(2, 1'b0);
    chk(16'(sref), 16'h0001);
    nop(2, 1'b1);
    chk(16'(sref), 16'h0);
    dchk = 1'b0;
    cmd(CMD_OPEN_ROW, 2'h0, 12'h0, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(2, 1'b1);
    cmd(CMD_READ, 2'h0, 12'h0, 2'h0, 1'b1, 16'h0, 1'b0);
    nop(2, 1'b0);
    chk(16'({susp, pdn}), 16'h0002);
    nop(2, 1'b1);
    chk(16'(susp), 16'h0);
    nop(4, 1'b1);
    nop(2, 1'b0);
    chk(16'({susp, pdn}), 16'h0001);
    nop(2, 1'b1);
    chk(16'(pdn), 16'h0);
    conclude();
  end
endmodule

// >>> verilog/sdram_cmd_pkg.sv
// shared constants for the sdram command and bank control block
package sdram_cmd_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 12;
  localparam int COL_W = 8;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int MODE_W = 11;
  localparam int ROW_KEEP = 2;
  localparam int MEM_AW = BA_W + ROW_KEEP + COL_W;
  localparam int MEM_WORDS = 4096;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_CW = 3;

  // ---------------------------------------------------------------
  // command codes {chip select, row, column, write strobe}, low active
  // ---------------------------------------------------------------
  typedef logic [3:0] cmd_t;
  localparam cmd_t CMD_MODE_SET = 4'h0;
  localparam cmd_t CMD_REFRESH = 4'h1;
  localparam cmd_t CMD_CLOSE = 4'h2;
  localparam cmd_t CMD_OPEN_ROW = 4'h3;
  localparam cmd_t CMD_WRITE = 4'h4;
  localparam cmd_t CMD_READ = 4'h5;
  localparam cmd_t CMD_BURST_STOP = 4'h6;
  localparam cmd_t CMD_NOP = 4'h7;

  // ---------------------------------------------------------------
  // mode word fields, word is {A11, A9..A0}
  // ---------------------------------------------------------------
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_MSB = 2;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_CL_MSB = 6;
  localparam int MODE_WB_BIT = 9;
  localparam int PALL_BIT = 10;
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;
  localparam logic [MODE_W-1:0] MODE_RESET = 11'h020;

  // ---------------------------------------------------------------
  // timing in link clock edges, and the bank reset state
  // ---------------------------------------------------------------
  localparam int MODE_SET_EDGES = 2;
  localparam int DQM_LAT = 2;
  localparam logic [BANKS-1:0] BANK_RESET = 4'h0;

endpackage

// >>> verilog/sdram_command_bank_control.sv
// sdram command decode, bank state, read bursts and clock-enable modes
`timescale 1ns/10ps
module sdram_command_bank_control
  import sdram_cmd_pkg::*;
(
  input wire logic clk_sys,                            // 20 MHz system clock
  input wire logic nrst,                               // async reset, low active
  input wire logic sdram_clk,                          // link clock pin
  input wire logic cke,                                // clock enable pin
  input wire logic cs_n,                               // chip select pin
  input wire logic ras_n,                              // row strobe pin
  input wire logic cas_n,                              // column strobe pin
  input wire logic we_n,                               // write strobe pin
  input wire logic [sdram_cmd_pkg::BA_W-1:0] bank_select, // bank select pins
  input wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr,   // address pins
  input wire logic [sdram_cmd_pkg::LANES-1:0] dqm,     // byte mask pins
  input wire logic [sdram_cmd_pkg::DATA_W-1:0] data_pins_in, // data pins, input
  output logic [sdram_cmd_pkg::DATA_W-1:0] data_pins_out, // data pins, output
  output logic [sdram_cmd_pkg::DATA_W-1:0] data_pins_oe,  // data pins, drive
  output logic [sdram_cmd_pkg::BANKS-1:0] bank_open,   // per bank active
  output logic [sdram_cmd_pkg::MODE_W-1:0] mode_word,  // applied mode word
  output logic clock_suspend_on,                       // in clock suspend
  output logic power_down_on,                          // in power down
  output logic self_refresh_on,                        // in self refresh
  output logic auto_refresh_pulse                      // one auto refresh
);
  import sdram_cmd_pkg::*;

  // ---------------------------------------------------------------
  // pin synchroniser and link clock edge
  // ---------------------------------------------------------------
  localparam int PIN_W = 2 + 4 + BA_W + ADDR_W + LANES + DATA_W;

  typedef enum logic [1:0] {PS_NORMAL, PS_SUSPEND, PS_POWER_DOWN, PS_SELF_REFRESH} pwr_e;

  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic clk_prev_q;
  logic clk_s;
  logic cke_s;
  cmd_t cmd_s;
  logic [BA_W-1:0] ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic [LANES-1:0] dqm_s;
  logic [DATA_W-1:0] din_s;
  logic rise;
  logic precharge_all_select;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {sdram_clk, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr, dqm,
                  data_pins_in};
      sync2_q <= sync1_q;
      clk_prev_q <= clk_s;
    end
  end

  assign {clk_s, cke_s, cmd_s, ba_s, addr_s, dqm_s, din_s} = sync2_q;
  assign rise = clk_s & ~clk_prev_q;
  assign precharge_all_select = addr_s[PALL_BIT];

  // ---------------------------------------------------------------
  // state registers and command qualification
  // ---------------------------------------------------------------
  logic cke_prev_q;
  pwr_e pwr_q;
  logic [BANKS-1:0] bank_open_q;
  logic [ROW_KEEP-1:0] row_q [BANKS];
  logic [MODE_W-1:0] mode_q;
  logic [MODE_W-1:0] mode_new_q;
  logic [1:0] mode_cnt_q;
  logic burst_on_q;
  logic burst_wr_q;
  logic burst_ap_q;
  logic [BA_W-1:0] burst_bank_q;
  logic [COL_W-1:0] burst_start_q;
  logic [COL_W-1:0] burst_cnt_q;
  logic [LANES-1:0] dqm_pipe_q [DQM_LAT];
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W:0] fifo_out_data;
  logic [FIFO_CW-1:0] fifo_count;
  logic edge_ok;
  logic step;
  logic any_open;
  logic open_ok;
  logic close_ok;
  logic rd_ok;
  logic wr_ok;
  logic mode_ok;
  logic ref_ok;
  logic stop_ok;
  logic new_burst;
  logic trunc_close;
  logic full_page;
  logic cur_wr;
  logic cur_ap;
  logic cur_last;
  logic word_on;
  logic burst_busy;
  logic [FIFO_CW-1:0] rd_pend_q;
  logic pop;
  logic mode_apply;
  logic [BA_W-1:0] cur_bank;
  logic [COL_W-1:0] cur_col;
  logic [COL_W-1:0] cur_cnt;
  logic [COL_W-1:0] cur_mask;
  logic [MEM_AW-1:0] mem_idx;
  logic [DATA_W-1:0] rd_word;

  assign edge_ok = rise & cke_prev_q;
  assign step = edge_ok & fifo_in_ready;
  assign any_open = |bank_open_q;

  // deselect and no-operation match none of these codes
  assign open_ok = step && cmd_s == CMD_OPEN_ROW && !bank_open_q[ba_s];
  assign close_ok = step && cmd_s == CMD_CLOSE;
  assign rd_ok = step && cmd_s == CMD_READ && bank_open_q[ba_s];
  assign wr_ok = step && cmd_s == CMD_WRITE && bank_open_q[ba_s];
  assign mode_ok = step && cmd_s == CMD_MODE_SET && !any_open;
  assign ref_ok = step && cmd_s == CMD_REFRESH && !any_open;
  assign stop_ok = step && cmd_s == CMD_BURST_STOP && burst_on_q;

  // ---------------------------------------------------------------
  // burst address generation
  // ---------------------------------------------------------------
  function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code);
    unique case (code)
      3'h0: len_mask = 8'h00;
      3'h1: len_mask = 8'h01;
      3'h2: len_mask = 8'h03;
      3'h3: len_mask = 8'h07;
      BL_FULL_PAGE: len_mask = 8'hFF;
      default: len_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] start,
                                              input logic [COL_W-1:0] cnt,
                                              input logic [COL_W-1:0] msk,
                                              input logic il);
    logic [COL_W-1:0] seq;
    seq = COL_W'(start + cnt);
    col_of = (start & ~msk) | ((il ? (start ^ cnt) : seq) & msk);
  endfunction

  assign full_page = mode_q[MODE_BL_MSB:MODE_BL_LSB] == BL_FULL_PAGE;
  assign new_burst = rd_ok | wr_ok;
  assign cur_wr = new_burst ? (cmd_s == CMD_WRITE) : burst_wr_q;
  assign cur_bank = new_burst ? ba_s : burst_bank_q;
  assign cur_cnt = new_burst ? '0 : burst_cnt_q;
  assign cur_mask = (cur_wr && mode_q[MODE_WB_BIT]) ? '0 :
                    len_mask(mode_q[MODE_BL_MSB:MODE_BL_LSB]);
  assign cur_col = new_burst ? addr_s[COL_W-1:0] :
                   col_of(burst_start_q, burst_cnt_q, cur_mask,
                          mode_q[MODE_BT_BIT] && !full_page);
  assign cur_ap = new_burst ? (precharge_all_select && !full_page) : burst_ap_q;
  assign cur_last = (cur_mask == '0 || !full_page || (cur_wr && mode_q[MODE_WB_BIT]))
                    && cur_cnt == cur_mask;
  assign trunc_close = close_ok && burst_on_q &&
                       (precharge_all_select || ba_s == burst_bank_q);
  assign word_on = new_burst || (step && burst_on_q && !stop_ok && !trunc_close);
  // idle filler words in the latency fifo must not block power down or self refresh
  assign burst_busy = burst_on_q | new_burst | (rd_pend_q != '0);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      burst_on_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_ap_q <= 1'b0;
      burst_bank_q <= '0;
      burst_start_q <= '0;
      burst_cnt_q <= '0;
    end else if (new_burst) begin
      burst_on_q <= !cur_last;
      burst_wr_q <= cur_wr;
      burst_ap_q <= cur_ap;
      burst_bank_q <= ba_s;
      burst_start_q <= addr_s[COL_W-1:0];
      burst_cnt_q <= 8'h01;
    end else if (word_on) begin
      burst_cnt_q <= COL_W'(burst_cnt_q + 1'b1);
      burst_on_q <= !cur_last;
    end else if (stop_ok || trunc_close) begin
      burst_on_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bank state and row latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bank_open_q <= BANK_RESET;
      for (int b = 0; b < BANKS; b++) begin
        row_q[b] <= '0;
      end
    end else begin
      if (open_ok) begin
        bank_open_q[ba_s] <= 1'b1;
        row_q[ba_s] <= addr_s[ROW_KEEP-1:0];
      end
      if (word_on && cur_last && cur_ap) begin
        bank_open_q[cur_bank] <= 1'b0;
      end
      if (close_ok) begin
        if (precharge_all_select) begin
          bank_open_q <= '0;
        end else begin
          bank_open_q[ba_s] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // mode register, applied two edges after the set command
  // ---------------------------------------------------------------
  assign mode_apply = step && !mode_ok && mode_cnt_q == 2'h1;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_q <= MODE_RESET;
      mode_new_q <= MODE_RESET;
      mode_cnt_q <= '0;
    end else if (mode_ok) begin
      mode_new_q <= {addr_s[11], addr_s[9:0]};
      mode_cnt_q <= 2'(MODE_SET_EDGES);
    end else if (step && mode_cnt_q != '0) begin
      mode_cnt_q <= 2'(mode_cnt_q - 1'b1);
      if (mode_apply) begin
        mode_q <= mode_new_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // clock enable modes and refresh
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cke_prev_q <= 1'b0;
    end else if (rise) begin
      cke_prev_q <= cke_s;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= PS_NORMAL;
    end else if (rise) begin
      unique case (pwr_q)
        PS_NORMAL: begin
          if (cke_prev_q && !cke_s) begin
            if (burst_busy) begin
              pwr_q <= PS_SUSPEND;
            end else if (ref_ok) begin
              pwr_q <= PS_SELF_REFRESH;
            end else begin
              pwr_q <= PS_POWER_DOWN;
            end
          end
        end
        PS_SUSPEND, PS_POWER_DOWN, PS_SELF_REFRESH: begin
          if (!cke_prev_q && cke_s) begin
            pwr_q <= PS_NORMAL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      auto_refresh_pulse <= 1'b0;
    end else begin
      auto_refresh_pulse <= ref_ok && cke_s;
    end
  end

  // ---------------------------------------------------------------
  // storage array, one per byte lane
  // ---------------------------------------------------------------
  assign mem_idx = {cur_bank, row_q[cur_bank], cur_col};

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [7:0] lane_mem [MEM_WORDS];
    always_ff @(posedge clk_sys) begin
      if (word_on && cur_wr && !dqm_s[g]) begin
        lane_mem[mem_idx] <= din_s[8*g +: 8];
      end
    end
    assign rd_word[8*g +: 8] = lane_mem[mem_idx];
  end

  // ---------------------------------------------------------------
  // read latency fifo, mask pipeline and data pin drive
  // ---------------------------------------------------------------
  assign pop = step && fifo_count >= mode_q[MODE_CL_MSB:MODE_CL_LSB];

  sdram_word_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .flush(mode_apply),
    .in_valid(edge_ok),
    .in_ready(fifo_in_ready),
    .in_data({word_on && !cur_wr, rd_word}),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  // read words still waiting in the latency fifo
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_pend_q <= '0;
    end else if (mode_apply) begin
      rd_pend_q <= '0;
    end else if (step) begin
      rd_pend_q <= FIFO_CW'(rd_pend_q + FIFO_CW'(word_on && !cur_wr)
                   - FIFO_CW'(pop && fifo_out_valid && fifo_out_data[DATA_W]));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DQM_LAT; i++) begin
        dqm_pipe_q[i] <= '0;
      end
    end else if (step) begin
      dqm_pipe_q[0] <= dqm_s;
      for (int i = 1; i < DQM_LAT; i++) begin
        dqm_pipe_q[i] <= dqm_pipe_q[i-1];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_pins_out <= '0;
      data_pins_oe <= '0;
    end else if (step) begin
      if (pop && fifo_out_valid) begin
        data_pins_out <= fifo_out_data[DATA_W-1:0];
        for (int g = 0; g < LANES; g++) begin
          data_pins_oe[8*g +: 8] <= {8{fifo_out_data[DATA_W] & ~dqm_pipe_q[DQM_LAT-1][g]}};
        end
      end else begin
        data_pins_oe <= '0;
      end
    end
  end

  assign bank_open = bank_open_q;
  assign mode_word = mode_q;
  assign clock_suspend_on = pwr_q == PS_SUSPEND;
  assign power_down_on = pwr_q == PS_POWER_DOWN;
  assign self_refresh_on = pwr_q == PS_SELF_REFRESH;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_cke_fall;
    rise && cke_prev_q && !cke_s && pwr_q == PS_NORMAL;
  endsequence

  sequence s_one_pulse;
    auto_refresh_pulse ##1 !auto_refresh_pulse;
  endsequence

  chk_edge_only: assert property (!rise |=> $stable(bank_open_q) && $stable(burst_cnt_q))
    else $error("state moved without a link clock edge");
  chk_open_bank: assert property (open_ok |=> bank_open_q[$past(ba_s)])
    else $error("open row did not open the bank");
  chk_close_one: assert property (close_ok && !precharge_all_select && !open_ok
      |=> !bank_open_q[$past(ba_s)])
    else $error("close did not close the selected bank");
  chk_close_all: assert property (close_ok && precharge_all_select |=> bank_open_q == '0)
    else $error("close all left a bank open");
  chk_mode_idle: assert property (step && cmd_s == CMD_MODE_SET && any_open
      && mode_cnt_q == '0 |=> mode_cnt_q == '0)
    else $error("mode set accepted with a bank open");
  chk_stop_burst: assert property (stop_ok && !new_burst |=> !burst_on_q)
    else $error("burst stop did not end the burst");
  chk_self_ref: assert property (s_cke_fall ##0 (ref_ok && !burst_busy)
      |=> pwr_q == PS_SELF_REFRESH)
    else $error("self refresh not entered");
  chk_auto_ref: assert property (ref_ok && cke_s |=> s_one_pulse)
    else $error("auto refresh pulse wrong");
  chk_suspend_entry: assert property (s_cke_fall ##0 burst_busy |=> clock_suspend_on
      && !power_down_on)
    else $error("burst not suspended on clock enable low");
  chk_mask_lane: assert property (step && pop && fifo_out_valid
      && dqm_pipe_q[DQM_LAT-1][0] |=> data_pins_oe[7:0] == 8'h00)
    else $error("masked low byte was driven");
  chk_float_end: assert property (step && !(pop && fifo_out_valid) |=> data_pins_oe == '0)
    else $error("data pins driven with no read word");
  chk_read_trunc: assert property (rd_ok |=> burst_start_q == $past(addr_s[COL_W-1:0])
      && !burst_wr_q)
    else $error("read did not restart the burst");
  chk_close_trunc: assert property (trunc_close && !new_burst |=> !burst_on_q)
    else $error("close of read bank did not end the burst");
  chk_mode_load: assert property (mode_apply |=> mode_q == $past(mode_new_q))
    else $error("mode word not applied");
  chk_page_ap: assert property (rd_ok && precharge_all_select && full_page
      |=> !burst_ap_q && bank_open_q[$past(ba_s)])
    else $error("full page auto precharge not ignored");

endmodule

// >>> verilog/sdram_word_fifo.sv
// small fifo carrying read words from the array to the data pins
`timescale 1ns/10ps
module sdram_word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4,
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys,            // system clock
  input wire logic nrst,               // async reset, low active
  input wire logic flush,              // drop all entries
  input wire logic in_valid,           // push request
  output logic in_ready,               // room for a word
  input wire logic [WIDTH-1:0] in_data, // pushed word
  output logic out_valid,              // a word is held
  input wire logic out_ready,          // pop request
  output logic [WIDTH-1:0] out_data,   // oldest word
  output logic [CW-1:0] count          // words held
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = slot_q[rd_ptr_q];
  assign count = count_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (flush) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= CW'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_q <= CW'(count_q - 1'b1);
    end
  end

endmodule
